// ---- hw/ufc_params.svh ----
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

// register addresses on the special-function register port
`define UFC_ADDR_SCS   8'hd2
`define UFC_ADDR_SBUF  8'hd3
`define UFC_ADDR_FMODE 8'he5

// serial_control_status bit positions
`define UFC_SCS_OVR    7
`define UFC_SCS_PERR   6
`define UFC_SCS_THRE   5
`define UFC_SCS_REN    4
`define UFC_SCS_TBX    3
`define UFC_SCS_RBX    2
`define UFC_SCS_TI     1
`define UFC_SCS_RI     0

// frame_mode bit positions
`define UFC_FM_MCE     7
`define UFC_FM_PT_HI   6
`define UFC_FM_PT_LO   5
`define UFC_FM_PE      4
`define UFC_FM_DL_HI   3
`define UFC_FM_DL_LO   2
`define UFC_FM_XBE     1
`define UFC_FM_SBL     0

// reset values
`define UFC_FMODE_RESET 8'h0c
`define UFC_SBUF_RESET  8'h00

// rate ticks per bit time, and receive fifo depth in bytes
`define UFC_OVS        16
`define UFC_RX_DEPTH   3

`endif

// ---- hw/ufc_pkg.sv ----
package ufc_pkg;

	typedef enum logic [1:0] {
		UFC_PAR_ODD   = 2'h0,
		UFC_PAR_EVEN  = 2'h1,
		UFC_PAR_MARK  = 2'h2,
		UFC_PAR_SPACE = 2'h3
	} ufc_par_t;

	typedef enum {UFC_TX_IDLE, UFC_TX_START, UFC_TX_DATA, UFC_TX_EXTRA, UFC_TX_STOP} ufc_tx_state_t;
	typedef enum {UFC_RX_IDLE, UFC_RX_START, UFC_RX_DATA, UFC_RX_EXTRA, UFC_RX_STOP} ufc_rx_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       xbit;
		logic       bad_par;
	} ufc_rx_entry_t;

endpackage : ufc_pkg

// ---- hw/ufc_fifo_if.sv ----
interface ufc_fifo_if #(parameter int W = 10, parameter int LW = 2);
	logic          push_valid;
	logic          push_ready;
	logic [W-1:0]  push_data;
	logic          pop_valid;
	logic          pop_ready;
	logic [W-1:0]  pop_data;
	logic [LW-1:0] level;

	modport fill  (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, level);
	modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
endinterface : ufc_fifo_if

// ---- hw/ufc_sync.sv ----
module ufc_sync (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// asynchronous level in, filtered level out
	input  wire logic d,
	output logic      q
);
	logic s1_q, s2_q, s3_q;

	// the level changes only once the second and third stages agree
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			q    <= 1'b1;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule : ufc_sync

// ---- hw/ufc_fifo.sv ----
module ufc_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 3
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// both ports
	ufc_fifo_if.store f
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || W < 1) begin : g_chk
		$error("ufc_fifo: depth must be at least 2");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [LW-1:0] lvl_q;
	logic          do_push;
	logic          do_pop;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		nxt = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : nxt

	assign f.push_ready = (lvl_q != LW'(DEPTH));
	assign f.pop_valid  = (lvl_q != '0);
	assign f.pop_data   = mem_q[rd_q];
	assign f.level      = lvl_q;
	assign do_push      = f.push_valid && f.push_ready;
	assign do_pop       = f.pop_valid && f.pop_ready;

	always_ff @(posedge clock) begin
		if (do_push) begin
			mem_q[wr_q] <= f.push_data;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			lvl_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= nxt(wr_q);
			end
			if (do_pop) begin
				rd_q <= nxt(rd_q);
			end
			if (do_push && !do_pop) begin
				lvl_q <= LW'(lvl_q + 1'b1);
			end else if (do_pop && !do_push) begin
				lvl_q <= LW'(lvl_q - 1'b1);
			end
		end
	end
endmodule : ufc_fifo

// ---- hw/ufc_uart_core.sv ----
`include "ufc_params.svh"

module ufc_uart_core
	import ufc_pkg::*;
#(
	parameter int OVS      = `UFC_OVS,
	parameter int RX_DEPTH = `UFC_RX_DEPTH
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic [7:0]      sfr_rdata,
	// bit-rate tick, OVS ticks per bit
	input  wire logic       rate_tick,
	// serial line
	input  wire logic       rx_pin,
	output logic            tx_pin,
	// interrupt request level to the interrupt controller
	output logic            port_event
);
	localparam int CW = $clog2(2 * OVS + 1);
	localparam int LW = $clog2(RX_DEPTH + 1);
	localparam logic [CW-1:0] BIT_LAST  = CW'(OVS - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(OVS / 2 - 1);

	if (OVS < 4 || (OVS % 2) != 0 || RX_DEPTH < 2) begin : g_chk
		$error("ufc_uart_core: OVS must be even and at least 4, depth at least 2");
	end

	// register state
	logic [7:0] fmode_q;
	logic       ovr_q;
	logic       perr_q;
	logic       ren_q;
	logic       tbx_q;
	logic       ti_q;
	logic       ri_q;
	logic [7:0] rdata_q;

	// mode fields
	logic       mce;
	logic       pe;
	logic       xbe;
	logic       sbl;
	logic [1:0] pt;
	logic [1:0] dl;
	logic       frame_x;
	logic       mce_eff;
	logic [3:0] nbits;

	// decode
	logic wr_scs;
	logic wr_fmode;
	logic wr_sbuf;
	logic rd_sbuf;

	// transmit side
	ufc_tx_state_t tx_st_q;
	logic [7:0]    hold_q;
	logic          hold_full_q;
	logic [7:0]    tx_sh_q;
	logic          tx_x_q;
	logic [CW-1:0] tx_cnt_q;
	logic [3:0]    tx_idx_q;
	logic          tx_q;
	logic          tx_load;
	logic          tx_bit_end;
	logic          tx_enter_stop;

	// receive side
	ufc_rx_state_t rx_st_q;
	logic          rx_lv;
	logic [7:0]    rx_sh_q;
	logic          rx_x_q;
	logic          rx_s1_q;
	logic          rx_stop2_q;
	logic [CW-1:0] rx_cnt_q;
	logic [3:0]    rx_idx_q;
	logic          rx_bit_end;
	logic          rx_long;
	logic          rx_fin;
	logic          rx_stops_ok;
	logic          rx_first_stop;
	logic          rx_keep;
	logic          ovr_set;
	logic          ri_set;
	logic          perr_set;
	ufc_rx_entry_t rx_new;
	ufc_rx_entry_t rx_head;

	ufc_fifo_if #(.W($bits(ufc_rx_entry_t)), .LW(LW)) rxf ();

	// parity bit of the low dl+5 data bits for the selected type
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] dlen, input logic [1:0] ptype);
		logic [7:0] m;
		logic       x;
		m = d & (8'hff >> (2'h3 - dlen));
		x = ^m;
		case (ptype)
			UFC_PAR_ODD:  par_bit = ~x;
			UFC_PAR_EVEN: par_bit = x;
			UFC_PAR_MARK: par_bit = 1'b1;
			default:      par_bit = 1'b0;
		endcase
	endfunction : par_bit

	// stop period in rate ticks
	function automatic logic [CW-1:0] stop_ticks(input logic long_sel, input logic [1:0] dlen);
		if (!long_sel) begin
			stop_ticks = CW'(OVS);
		end else if (dlen == 2'h0) begin
			stop_ticks = CW'(OVS + OVS / 2);
		end else begin
			stop_ticks = CW'(2 * OVS);
		end
	endfunction : stop_ticks

	assign mce     = fmode_q[`UFC_FM_MCE];
	assign pt      = fmode_q[`UFC_FM_PT_HI:`UFC_FM_PT_LO];
	assign pe      = fmode_q[`UFC_FM_PE];
	assign dl      = fmode_q[`UFC_FM_DL_HI:`UFC_FM_DL_LO];
	assign xbe     = fmode_q[`UFC_FM_XBE];
	assign sbl     = fmode_q[`UFC_FM_SBL];
	assign nbits   = 4'h5 + {2'h0, dl};
	assign frame_x = pe | xbe;
	assign mce_eff = mce & xbe & ~pe;

	assign wr_scs   = sfr_wr && (sfr_addr == `UFC_ADDR_SCS);
	assign wr_fmode = sfr_wr && (sfr_addr == `UFC_ADDR_FMODE);
	assign wr_sbuf  = sfr_wr && (sfr_addr == `UFC_ADDR_SBUF);
	assign rd_sbuf  = sfr_rd && (sfr_addr == `UFC_ADDR_SBUF);

	assign sfr_rdata  = rdata_q;
	assign tx_pin     = tx_q;
	assign port_event = ti_q | ri_q;

	// ---------------- transmit ----------------
	assign tx_load       = (tx_st_q == UFC_TX_IDLE) && hold_full_q;
	assign tx_bit_end    = rate_tick && (tx_cnt_q == BIT_LAST);
	assign tx_enter_stop = tx_bit_end && (((tx_st_q == UFC_TX_DATA) && (tx_idx_q == nbits - 4'h1) && !frame_x)
		|| (tx_st_q == UFC_TX_EXTRA));

	// holding register; a write beside a load keeps the new byte held
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hold_q      <= `UFC_SBUF_RESET;
			hold_full_q <= 1'b0;
		end else if (wr_sbuf) begin
			hold_q      <= sfr_wdata;
			hold_full_q <= 1'b1;
		end else if (tx_load) begin
			hold_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_q  <= UFC_TX_IDLE;
			tx_sh_q  <= 8'h00;
			tx_x_q   <= 1'b0;
			tx_cnt_q <= '0;
			tx_idx_q <= 4'h0;
			tx_q     <= 1'b1;
		end else begin
			case (tx_st_q)
				UFC_TX_IDLE: begin
					if (tx_load) begin
						tx_sh_q  <= hold_q;
						tx_x_q   <= pe ? par_bit(hold_q, dl, pt) : tbx_q;
						tx_cnt_q <= '0;
						tx_q     <= 1'b0;
						tx_st_q  <= UFC_TX_START;
					end
				end
				UFC_TX_START: begin
					if (rate_tick) begin
						tx_cnt_q <= CW'(tx_cnt_q + 1'b1);
					end
					if (tx_bit_end) begin
						tx_cnt_q <= '0;
						tx_idx_q <= 4'h0;
						tx_q     <= tx_sh_q[0];
						tx_st_q  <= UFC_TX_DATA;
					end
				end
				UFC_TX_DATA: begin
					if (rate_tick) begin
						tx_cnt_q <= CW'(tx_cnt_q + 1'b1);
					end
					if (tx_bit_end) begin
						tx_cnt_q <= '0;
						if (tx_idx_q == nbits - 4'h1) begin
							if (frame_x) begin
								tx_q    <= tx_x_q;
								tx_st_q <= UFC_TX_EXTRA;
							end else begin
								tx_q    <= 1'b1;
								tx_st_q <= UFC_TX_STOP;
							end
						end else begin
							tx_idx_q <= tx_idx_q + 4'h1;
							tx_sh_q  <= tx_sh_q >> 1;
							tx_q     <= tx_sh_q[1];
						end
					end
				end
				UFC_TX_EXTRA: begin
					if (rate_tick) begin
						tx_cnt_q <= CW'(tx_cnt_q + 1'b1);
					end
					if (tx_bit_end) begin
						tx_cnt_q <= '0;
						tx_q     <= 1'b1;
						tx_st_q  <= UFC_TX_STOP;
					end
				end
				UFC_TX_STOP: begin
					if (rate_tick) begin
						if (tx_cnt_q == CW'(stop_ticks(sbl, dl) - 1'b1)) begin
							tx_cnt_q <= '0;
							tx_st_q  <= UFC_TX_IDLE;
						end else begin
							tx_cnt_q <= CW'(tx_cnt_q + 1'b1);
						end
					end
				end
				default: begin
					tx_q    <= 1'b1;
					tx_st_q <= UFC_TX_IDLE;
				end
			endcase
		end
	end

	// ---------------- receive ----------------
	ufc_sync u_rx_sync (
		.clock (clock),
		.rst_b (rst_b),
		.d     (rx_pin),
		.q     (rx_lv)
	);

	assign rx_bit_end    = rate_tick && (rx_cnt_q == BIT_LAST);
	assign rx_long       = sbl && (dl != 2'h0);
	assign rx_fin        = rx_bit_end && (rx_st_q == UFC_RX_STOP) && (rx_stop2_q || !rx_long);
	assign rx_first_stop = rx_stop2_q ? rx_s1_q : rx_lv;
	assign rx_stops_ok   = rx_lv && rx_first_stop;
	assign rx_new        = '{data: rx_sh_q,
		xbit: (xbe ? rx_x_q : rx_first_stop),
		bad_par: (pe && (rx_x_q != par_bit(rx_sh_q, dl, pt)))};
	assign rx_keep       = rx_fin && rx_stops_ok && !(mce_eff && !rx_x_q);
	assign rxf.push_valid = rx_keep;
	assign rxf.push_data  = rx_new;
	assign rxf.pop_ready  = rd_sbuf;
	assign rx_head        = rxf.pop_data;
	assign ovr_set  = rx_keep && !rxf.push_ready;
	assign ri_set   = rx_keep && rxf.push_ready;
	assign perr_set = pe && rxf.pop_valid && rx_head.bad_par;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_q    <= UFC_RX_IDLE;
			rx_sh_q    <= 8'h00;
			rx_x_q     <= 1'b0;
			rx_s1_q    <= 1'b0;
			rx_stop2_q <= 1'b0;
			rx_cnt_q   <= '0;
			rx_idx_q   <= 4'h0;
		end else begin
			case (rx_st_q)
				UFC_RX_IDLE: begin
					if (ren_q && !rx_lv) begin
						rx_cnt_q <= '0;
						rx_st_q  <= UFC_RX_START;
					end
				end
				UFC_RX_START: begin
					if (rate_tick) begin
						rx_cnt_q <= CW'(rx_cnt_q + 1'b1);
						if (rx_cnt_q == HALF_LAST) begin
							rx_cnt_q <= '0;
							rx_idx_q <= 4'h0;
							rx_sh_q  <= 8'h00;
							rx_st_q  <= rx_lv ? UFC_RX_IDLE : UFC_RX_DATA;
						end
					end
				end
				UFC_RX_DATA: begin
					if (rate_tick) begin
						rx_cnt_q <= CW'(rx_cnt_q + 1'b1);
					end
					if (rx_bit_end) begin
						rx_cnt_q           <= '0;
						rx_sh_q[rx_idx_q[2:0]] <= rx_lv;
						rx_stop2_q         <= 1'b0;
						if (rx_idx_q == nbits - 4'h1) begin
							rx_st_q <= frame_x ? UFC_RX_EXTRA : UFC_RX_STOP;
						end else begin
							rx_idx_q <= rx_idx_q + 4'h1;
						end
					end
				end
				UFC_RX_EXTRA: begin
					if (rate_tick) begin
						rx_cnt_q <= CW'(rx_cnt_q + 1'b1);
					end
					if (rx_bit_end) begin
						rx_cnt_q <= '0;
						rx_x_q   <= rx_lv;
						rx_st_q  <= UFC_RX_STOP;
					end
				end
				UFC_RX_STOP: begin
					if (rate_tick) begin
						rx_cnt_q <= CW'(rx_cnt_q + 1'b1);
					end
					if (rx_bit_end) begin
						rx_cnt_q <= '0;
						if (rx_fin) begin
							rx_st_q <= UFC_RX_IDLE;
						end else begin
							rx_s1_q    <= rx_lv;
							rx_stop2_q <= 1'b1;
						end
					end
				end
				default: begin
					rx_st_q <= UFC_RX_IDLE;
				end
			endcase
		end
	end

	ufc_fifo #(
		.W     ($bits(ufc_rx_entry_t)),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clock (clock),
		.rst_b (rst_b),
		.f     (rxf)
	);

	// ---------------- registers ----------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fmode_q <= `UFC_FMODE_RESET;
		end else if (wr_fmode) begin
			fmode_q <= sfr_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ren_q <= 1'b0;
			tbx_q <= 1'b0;
		end else if (wr_scs) begin
			ren_q <= sfr_wdata[`UFC_SCS_REN];
			tbx_q <= sfr_wdata[`UFC_SCS_TBX];
		end
	end

	// sticky flags: a hardware set wins over a software write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ovr_q  <= 1'b0;
			perr_q <= 1'b0;
			ti_q   <= 1'b0;
		end else begin
			ovr_q  <= ovr_set | (wr_scs ? sfr_wdata[`UFC_SCS_OVR] : ovr_q);
			perr_q <= perr_set | (wr_scs ? sfr_wdata[`UFC_SCS_PERR] : perr_q);
			ti_q   <= tx_enter_stop | (wr_scs ? sfr_wdata[`UFC_SCS_TI] : ti_q);
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ri_q <= 1'b0;
		end else if (ri_set) begin
			ri_q <= 1'b1;
		end else if (wr_scs && sfr_wdata[`UFC_SCS_RI]) begin
			ri_q <= 1'b1;
		end else if (wr_scs && (rxf.level <= LW'(1))) begin
			ri_q <= 1'b0;
		end
	end

	// read data is registered: it appears the cycle after the read strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`UFC_ADDR_SCS:   rdata_q <= {ovr_q, perr_q, ~hold_full_q, ren_q, tbx_q,
					rx_head.xbit & rxf.pop_valid & ~pe, ti_q, ri_q};
				`UFC_ADDR_FMODE: rdata_q <= fmode_q;
				`UFC_ADDR_SBUF:  rdata_q <= rxf.pop_valid ? rx_head.data : 8'h00;
				default:         rdata_q <= 8'h00;
			endcase
		end
	end
endmodule : ufc_uart_core

// ---- dv/ufc_uart_core_monitor.sv ----
module ufc_uart_core_monitor #(
	parameter int OVS      = 16,
	parameter int RX_DEPTH = 3
) (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst_b,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// tick, lines and event
	input wire logic       rate_tick,
	input wire logic       rx_pin,
	input wire logic       tx_pin,
	input wire logic       port_event
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [15:0] lo_q;
	logic [15:0] hi_q;
	// ticks spent in the current low and high runs of the transmit line
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) lo_q <= '0;
		else if (tx_pin) lo_q <= '0;
		else if (rate_tick) lo_q <= lo_q + 16'h1;
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) hi_q <= '0;
		else if (!tx_pin) hi_q <= '0;
		else if (rate_tick && hi_q != 16'hffff) hi_q <= hi_q + 16'h1;
	end
	a_reset_idle: assert property ($rose(rst_b) |-> tx_pin && !port_event)
		else $error("line or event not idle after reset");
	a_tx_on_write: assert property (sfr_wr && sfr_addr == 8'hd3 && tx_pin && hi_q >= 12 * OVS |-> ##[1:2] !tx_pin)
		else $error("buffer write did not start a frame");
	a_rise_on_tick: assert property ($rose(tx_pin) |-> $past(rate_tick) || $past(rate_tick, 2))
		else $error("transmit edge off the rate tick");
	a_start_len: assert property ($rose(tx_pin) |-> lo_q >= OVS)
		else $error("low run shorter than one bit");
	a_high_len: assert property ($fell(tx_pin) |-> hi_q >= OVS)
		else $error("high run shorter than one bit");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (sfr_rd && !(sfr_addr inside {8'hd2, 8'hd3, 8'he5}) |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mode_back: assert property (sfr_wr && sfr_addr == 8'he5 ##2 sfr_rd && sfr_addr == 8'he5 |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("frame mode read back differs");
	a_event_cause: assert property ($rose(port_event) |-> tx_pin || rx_pin || $past(sfr_wr))
		else $error("event raised without cause");
	c_tx_load: cover property (sfr_wr && sfr_addr == 8'hd3 ##[1:2] $fell(tx_pin));
	c_event: cover property ($rose(port_event));
	c_pop: cover property (sfr_rd && sfr_addr == 8'hd3);
endmodule : ufc_uart_core_monitor

// ---- dv/ufc_serial_node.sv ----
module ufc_serial_node #(
	parameter int OVS = 16
) (
	// clock and bit-rate tick
	input wire logic clock,
	input wire logic rate_tick,
	// lines toward and from the port
	output logic     node_tx,
	input wire logic node_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// the line idles high, as a pulled-up serial line does
	initial node_tx = 1'b1;
	task automatic ticks(input int n);
		repeat (n) @(posedge clock iff rate_tick);
	endtask : ticks
	task automatic send(input logic [7:0] d, input int nb, input logic hx, input logic x, input logic stp);
		node_tx <= 1'b0;
		ticks(OVS);
		for (int i = 0; i < nb; i++) begin
			node_tx <= d[i];
			ticks(OVS);
		end
		if (hx) begin
			node_tx <= x;
			ticks(OVS);
		end
		node_tx <= stp;
		ticks(OVS);
		node_tx <= 1'b1;
		ticks(OVS);
	endtask : send
	// samples each bit at its centre; f holds {stop, extra, data}
	task automatic grab(input int nb, input logic hx, output logic [9:0] f);
		f = '0;
		wait (node_rx === 1'b0);
		ticks(OVS / 2);
		for (int i = 0; i < nb; i++) begin
			ticks(OVS);
			f[i] = node_rx;
		end
		if (hx) begin
			ticks(OVS);
			f[8] = node_rx;
		end
		ticks(OVS);
		f[9] = node_rx;
	endtask : grab
endmodule : ufc_serial_node

// ---- dv/uart_frame_control_status_bench.sv ----
module uart_frame_control_status_bench
	import ufc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OVS = 4;
	localparam logic [7:0] SC = 8'hd2;
	localparam logic [7:0] SB = 8'hd3;
	localparam logic [7:0] FM = 8'he5;
	typedef struct {logic [7:0] fm; logic [7:0] sc; logic [7:0] d; logic [7:0] ed; logic ex;} ufc_row_t;
	logic       clock;
	logic       rst_b;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       rate_tick;
	logic       rx_pin;
	logic       tx_pin;
	logic       port_event;
	logic [1:0] div_q;
	logic [9:0] fr;
	int         err_total;
	int         num_checks;
	int         cyc;
	logic [7:0] rxd [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	ufc_row_t   rows [6] = '{'{8'h0c, 8'h00, 8'ha5, 8'ha5, 1'b0}, '{8'h02, 8'h08, 8'hf3, 8'h13, 1'b1},
		'{8'h18, 8'h00, 8'h35, 8'h35, 1'b1}, '{8'h34, 8'h00, 8'hee, 8'h2e, 1'b0},
		'{8'h5c, 8'h00, 8'h81, 8'h81, 1'b1}, '{8'h7c, 8'h08, 8'h7e, 8'h7e, 1'b0}};

	ufc_uart_core #(.OVS(OVS), .RX_DEPTH(3)) ufc_uart_core_inst (.clock(clock), .rst_b(rst_b),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.rate_tick(rate_tick), .rx_pin(rx_pin), .tx_pin(tx_pin), .port_event(port_event));
	ufc_serial_node #(.OVS(OVS)) ufc_serial_node_inst (.clock(clock), .rate_tick(rate_tick),
		.node_tx(rx_pin), .node_rx(tx_pin));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// one rate tick every third clock
	always @(posedge clock) begin
		div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		rate_tick <= (div_q == 2'h2);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(posedge clock);
		chk(sfr_rdata & m, e);
	endtask : rdc
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rdc(SC, 8'hff, 8'h20);
		rdc(FM, 8'hff, 8'h0c);
		rdc(SB, 8'hff, 8'h00);
		rdc(8'hd4, 8'hff, 8'h00);
		$display("test reset done");
	endtask : do_reset
	// two writes in a row: the second byte must start right after the stop period
	task automatic b2b(input logic [7:0] f, input logic [7:0] m, input int g);
		int n;
		repeat (10 * OVS) @(posedge clock);
		wr(FM, f);
		fork
			begin
				ufc_serial_node_inst.grab(f[3:2] + 5, 1'b0, fr);
				chk(fr[7:0], 8'h5a & m);
				n = 0;
				do begin
					@(negedge clock);
					n++;
				end while (tx_pin === 1'b1);
				chk(8'(n), 8'(g));
				ufc_serial_node_inst.grab(f[3:2] + 5, 1'b0, fr);
				chk(fr[7:0], 8'hc3 & m);
			end
			begin
				wr(SB, 8'h5a);
				wr(SB, 8'hc3);
				rdc(SC, 8'h20, 8'h00);
			end
		join
	endtask : b2b
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		rst_b = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		rate_tick = 1'b0;
		div_q = 2'h0;
		err_total = 0;
		num_checks = 0;
		cyc = 0;
		do_reset();
		repeat (160) @(posedge clock);
		foreach (rows[i]) begin
			wr(FM, rows[i].fm);
			rdc(FM, 8'hff, rows[i].fm);
			wr(SC, rows[i].sc);
			fork
				ufc_serial_node_inst.grab(rows[i].fm[3:2] + 5, rows[i].fm[4] | rows[i].fm[1], fr);
				wr(SB, rows[i].d);
			join
			chk(fr[7:0], rows[i].ed);
			chk({7'h0, fr[8]}, {7'h0, rows[i].ex});
			chk({7'h0, fr[9]}, 8'h01);
			rdc(SC, 8'h22, 8'h22);
			wr(SC, 8'h00);
			rdc(SC, 8'h02, 8'h00);
			$display("test tx row %0d done", i);
		end
		b2b(8'h0d, 8'hff, 6 * OVS - 4);
		b2b(8'h01, 8'h1f, 9 * OVS / 2 - 4);
		b2b(8'h0c, 8'hff, 3 * OVS - 4);
		$display("test back to back done");
		wr(SC, 8'h10);
		foreach (rxd[i]) ufc_serial_node_inst.send(rxd[i], 8, 1'b0, 1'b0, 1'b1);
		rdc(SC, 8'hff, 8'hb5);
		chk({7'h0, port_event}, 8'h01);
		wr(SC, 8'h10);
		rdc(SC, 8'h81, 8'h01);
		rdc(SB, 8'hff, 8'h11);
		rdc(SB, 8'hff, 8'h22);
		rdc(SB, 8'hff, 8'h33);
		wr(SC, 8'h10);
		rdc(SC, 8'h81, 8'h00);
		ufc_serial_node_inst.send(8'h66, 8, 1'b0, 1'b0, 1'b0);
		rdc(SC, 8'h01, 8'h00);
		$display("test receive done");
		do_reset();
		ufc_serial_node_inst.send(8'h77, 8, 1'b0, 1'b0, 1'b1);
		rdc(SC, 8'h01, 8'h00);
		wr(FM, 8'h8e);
		wr(SC, 8'h10);
		ufc_serial_node_inst.send(8'h12, 8, 1'b1, 1'b0, 1'b1);
		rdc(SC, 8'h01, 8'h00);
		ufc_serial_node_inst.send(8'h34, 8, 1'b1, 1'b1, 1'b1);
		rdc(SC, 8'h05, 8'h05);
		rdc(SB, 8'hff, 8'h34);
		wr(FM, 8'h3c);
		wr(SC, 8'h10);
		ufc_serial_node_inst.send(8'h3c, 8, 1'b1, 1'b1, 1'b1);
		rdc(SC, 8'h45, 8'h41);
		rdc(SB, 8'hff, 8'h3c);
		$display("test filter and parity done");
		stop_test();
	end
endmodule : uart_frame_control_status_bench

bind ufc_uart_core ufc_uart_core_monitor #(.OVS(OVS), .RX_DEPTH(RX_DEPTH)) ufc_uart_core_monitor_inst (
	.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rate_tick(rate_tick), .rx_pin(rx_pin),
	.tx_pin(tx_pin), .port_event(port_event));
